// ### design/vectored_interrupt_and_event_unit.sv
// vectored interrupt unit with aux timers, comparator events and reset cause
// assumes core pulses its instruction strobes for one cycle, inputs synchronous
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_and_event_unit (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       clk_en_i,
    input  wire logic [1:0] space_i,
    input  wire logic [5:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       pin_reset_n_i,
    input  wire logic       watchdog_timeout_i,
    input  wire logic       global_irq_on_instr_i,
    input  wire logic       global_irq_off_instr_i,
    input  wire logic       irq_return_instr_i,
    input  wire logic       sleep_instr_i,
    input  wire logic       watchdog_clear_instr_i,
    input  wire logic       main_timer_ovf_i,
    input  wire logic       ext_pin_event_i,
    input  wire logic       ir_event_i,
    input  wire logic [7:0] port5_i,
    input  wire logic       port5_read_i,
    input  wire logic [3:0] comparator_raw_i,
    input  wire logic       aux_ext_tick_i,
    input  wire logic       irq_take_i,
    input  wire logic [7:0] acc_i,
    input  wire logic [7:0] status_i,
    output logic            irq_req_o,
    output logic      [9:0] vector_o,
    output logic      [7:0] saved_acc_o,
    output logic      [7:0] saved_status_o,
    output logic            core_reset_o,
    output logic            sleep_o,
    output logic            wake_o,
    output logic      [2:0] reset_cause_o,
    output logic      [3:0] comparator_enable_o,
    output logic      [3:0] input_sharing_select_o,
    output logic      [3:0] comparator_pin_o,
    output logic      [3:0] comparator_pin_oe_o
);
    typedef struct packed {
        logic        gie;
        logic        sleeping;
        logic        wake_flag;
        logic        timeout_flag;
        logic        powerdown_flag;
        logic        core_rst;
        logic        wake_pulse;
        logic [7:0]  flags;
        logic [7:0]  mask;
        logic [7:0]  tcr_one;
        logic [7:0]  tcr_two;
        logic [7:0]  cmp_ctrl;
        logic [3:0]  sharing;
        logic [3:0]  cmp_res;
        logic [2:0]  aux_flags;
        logic [7:0]  ta;
        logic [7:0]  ta_rel;
        logic [15:0] tb;
        logic [15:0] tb_rel;
        logic [7:0]  tc;
        logic [7:0]  tc_rel;
        logic [7:0]  p5_snap;
        logic [9:0]  vector;
        logic [7:0]  sacc;
        logic [7:0]  sstat;
        logic [7:0]  rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    localparam int NUM_SRC_W = irq_unit_pkg::NUM_SRC;
    logic [NUM_SRC_W-1:0] pending;

    // one aux timer step; returns {overflow, next count}
    function automatic logic [16:0] aux_step(
        input logic [15:0] cnt,
        input logic [15:0] rel,
        input logic [15:0] top,
        input logic        tick
    );
        logic [16:0] res;
        res = {1'b0, cnt};
        if (tick)
        begin
            if (cnt == top)
                res = {1'b1, rel};
            else
                res = {1'b0, cnt + 16'h0001};
        end
        return res;
    endfunction

    // pending sources in vector order: cmp4..cmp1, c, b, a, main, ext, port
    always_comb
    begin
        logic [7:0] req;
        req = state_reg.flags & state_reg.mask & irq_unit_pkg::FLAG_USED_MASK;
        pending = {req[irq_unit_pkg::BIT_PORT_CHANGE],
                   req[irq_unit_pkg::BIT_EXT_PIN],
                   req[irq_unit_pkg::BIT_MAIN_TIMER],
                   state_reg.aux_flags[0],
                   state_reg.aux_flags[1],
                   state_reg.aux_flags[2],
                   req[irq_unit_pkg::BIT_CMP_LOW],
                   req[irq_unit_pkg::BIT_CMP_LOW+1],
                   req[irq_unit_pkg::BIT_CMP_LOW+2],
                   req[irq_unit_pkg::BIT_CMP_LOW+3]};
    end

    always_comb
    begin
        logic        wr_oper;
        logic        wr_ctrl;
        logic        wr_cnt;
        logic [3:0]  cmp_en;
        logic [3:0]  cmp_change;
        logic        port_change;
        logic        wake_req;
        logic        tick_a;
        logic        tick_b;
        logic        tick_c;
        logic [16:0] step_a;
        logic [16:0] step_b;
        logic [16:0] step_c;
        logic [7:0]  flag_set;
        logic [2:0]  aux_set;
        logic [3:0]  sel;
        logic        found;
        state_next = state_reg;
        wr_oper = wr_i && (space_i == irq_unit_pkg::SPACE_OPER);
        wr_ctrl = wr_i && (space_i == irq_unit_pkg::SPACE_CTRL);
        wr_cnt  = wr_i && (space_i == irq_unit_pkg::SPACE_CNT);
        state_next.core_rst   = 1'b0;
        state_next.wake_pulse = 1'b0;

        // comparators: enabled ones track, disabled ones hold
        cmp_en = state_reg.cmp_ctrl[irq_unit_pkg::CMP_EN_LOW +: irq_unit_pkg::NUM_CMP];
        cmp_change = cmp_en & (comparator_raw_i ^ state_reg.cmp_res);
        state_next.cmp_res = (comparator_raw_i & cmp_en)
                           | (state_reg.cmp_res & ~cmp_en);

        // port change against snapshot taken at last port read
        port_change = |(port5_i ^ state_reg.p5_snap);
        if (port5_read_i)
            state_next.p5_snap = port5_i;

        // flag sets; port change flag alone obeys its mask bit
        flag_set = '0;
        flag_set[irq_unit_pkg::BIT_MAIN_TIMER] = main_timer_ovf_i;
        flag_set[irq_unit_pkg::BIT_EXT_PIN] = ext_pin_event_i;
        flag_set[irq_unit_pkg::BIT_PORT_CHANGE] =
            port_change && state_reg.mask[irq_unit_pkg::BIT_PORT_CHANGE];
        flag_set[irq_unit_pkg::BIT_CMP_LOW +: irq_unit_pkg::NUM_CMP] = cmp_change;

        // aux timers
        tick_a = state_reg.tcr_one[irq_unit_pkg::BIT_RUN_EN]
              && (!state_reg.tcr_one[irq_unit_pkg::BIT_SRC_SEL] || aux_ext_tick_i);
        tick_b = state_reg.tcr_two[irq_unit_pkg::TB_NIBBLE + irq_unit_pkg::BIT_RUN_EN]
              && (!state_reg.tcr_two[irq_unit_pkg::TB_NIBBLE + irq_unit_pkg::BIT_SRC_SEL]
                  || aux_ext_tick_i);
        tick_c = state_reg.tcr_two[irq_unit_pkg::BIT_RUN_EN]
              && (!state_reg.tcr_two[irq_unit_pkg::BIT_SRC_SEL] || aux_ext_tick_i);
        step_a = aux_step({8'h00, state_reg.ta}, {8'h00, state_reg.ta_rel},
                          irq_unit_pkg::TOP_8, tick_a);
        step_b = aux_step(state_reg.tb, state_reg.tb_rel, irq_unit_pkg::TOP_16, tick_b);
        step_c = aux_step({8'h00, state_reg.tc}, {8'h00, state_reg.tc_rel},
                          irq_unit_pkg::TOP_8, tick_c);
        state_next.ta = step_a[7:0];
        state_next.tb = step_b[15:0];
        state_next.tc = step_c[7:0];
        aux_set[0] = step_a[16] && state_reg.tcr_one[irq_unit_pkg::BIT_IRQ_EN];
        aux_set[1] = step_b[16]
                  && state_reg.tcr_two[irq_unit_pkg::TB_NIBBLE + irq_unit_pkg::BIT_IRQ_EN];
        aux_set[2] = step_c[16] && state_reg.tcr_two[irq_unit_pkg::BIT_IRQ_EN];

        // software writes; writing 0 clears a flag, a same-cycle set wins
        if (wr_oper)
        begin
            unique case (addr_i)
                irq_unit_pkg::OFF_TIMER_CMP_STATUS:
                    state_next.aux_flags = state_reg.aux_flags & wdata_i[2:0];
                irq_unit_pkg::OFF_TIMER_CTRL_ONE:
                    state_next.tcr_one = wdata_i & irq_unit_pkg::TCR_ONE_MASK;
                irq_unit_pkg::OFF_TIMER_CTRL_TWO:
                    state_next.tcr_two = wdata_i & irq_unit_pkg::TCR_TWO_MASK;
                irq_unit_pkg::OFF_IRQ_FLAGS:
                    state_next.flags = state_reg.flags & wdata_i;
                default:
                    state_next.flags = state_reg.flags;
            endcase
        end
        if (wr_ctrl)
        begin
            unique case (addr_i)
                irq_unit_pkg::OFF_CMP_CTRL:
                    state_next.cmp_ctrl = wdata_i;
                irq_unit_pkg::OFF_CMP_SHARING:
                    state_next.sharing = wdata_i[3:0];
                irq_unit_pkg::OFF_IRQ_MASK:
                    state_next.mask = wdata_i & irq_unit_pkg::FLAG_USED_MASK;
                default:
                    state_next.mask = state_reg.mask;
            endcase
        end
        if (wr_cnt)
        begin
            unique case (addr_i)
                irq_unit_pkg::OFF_AUX_A_COUNT:
                begin
                    state_next.ta = wdata_i;
                    state_next.ta_rel = wdata_i;
                end
                irq_unit_pkg::OFF_AUX_B_LOW:
                begin
                    state_next.tb[7:0] = wdata_i;
                    state_next.tb_rel[7:0] = wdata_i;
                end
                irq_unit_pkg::OFF_AUX_B_HIGH:
                begin
                    state_next.tb[15:8] = wdata_i;
                    state_next.tb_rel[15:8] = wdata_i;
                end
                irq_unit_pkg::OFF_AUX_C_COUNT:
                begin
                    state_next.tc = wdata_i;
                    state_next.tc_rel = wdata_i;
                end
                default:
                    state_next.ta = step_a[7:0];
            endcase
        end
        state_next.flags = (state_next.flags | flag_set) & irq_unit_pkg::FLAG_USED_MASK;
        state_next.aux_flags = state_next.aux_flags | aux_set;

        // global enable
        if (global_irq_off_instr_i)
            state_next.gie = 1'b0;
        if (global_irq_on_instr_i || irq_return_instr_i)
            state_next.gie = 1'b1;

        // interrupt entry: lowest vector first, context saved once
        sel = '0;
        found = 1'b0;
        for (int i = 0; i < irq_unit_pkg::NUM_SRC; i++)
        begin
            if (pending[i] && !found)
            begin
                sel = 4'(i);
                found = 1'b1;
            end
        end
        if (irq_take_i && irq_req_o)
        begin
            state_next.vector = irq_unit_pkg::VECTOR_BASE
                              + 10'(sel) * irq_unit_pkg::VECTOR_STEP;
            state_next.sacc = acc_i;
            state_next.sstat = status_i;
            state_next.gie = 1'b0;
        end

        // cause bits on instructions
        if (watchdog_clear_instr_i)
        begin
            state_next.timeout_flag = 1'b1;
            state_next.powerdown_flag = 1'b1;
        end
        if (sleep_instr_i)
        begin
            state_next.timeout_flag = 1'b1;
            state_next.powerdown_flag = 1'b0;
            state_next.sleeping = 1'b1;
        end

        // wake from sleep; ir event only wakes, it has no flag of its own
        wake_req = (port_change && state_reg.mask[irq_unit_pkg::BIT_PORT_CHANGE])
                || |(cmp_change
                     & state_reg.mask[irq_unit_pkg::BIT_CMP_LOW +: irq_unit_pkg::NUM_CMP])
                || ir_event_i;
        if (state_reg.sleeping && wake_req)
        begin
            state_next.sleeping = 1'b0;
            state_next.wake_pulse = 1'b1;
            if (port_change && state_reg.mask[irq_unit_pkg::BIT_PORT_CHANGE])
            begin
                state_next.wake_flag = 1'b1;
                state_next.timeout_flag = 1'b1;
                state_next.powerdown_flag = 1'b0;
            end
        end

        // pin and watchdog resets: same bookkeeping running or asleep
        if (watchdog_timeout_i || !pin_reset_n_i)
        begin
            state_next.core_rst = 1'b1;
            state_next.sleeping = 1'b0;
            state_next.wake_flag = 1'b0;
            if (watchdog_timeout_i)
                state_next.timeout_flag = 1'b0;
            state_next.ta = '0;
            state_next.tb = '0;
            state_next.tc = '0;
            state_next.flags = '0;
            state_next.mask = '0;
            state_next.cmp_ctrl = '0;
            state_next.sharing = '0;
            state_next.gie = 1'b0;
        end

        // read data, valid the cycle after the strobe
        state_next.rdata = '0;
        if (rd_i)
        begin
            unique case (space_i)
                irq_unit_pkg::SPACE_OPER:
                begin
                    unique case (addr_i)
                        irq_unit_pkg::OFF_TIMER_CMP_STATUS:
                            state_next.rdata = {state_reg.cmp_res, 1'b0,
                                                state_reg.aux_flags};
                        irq_unit_pkg::OFF_TIMER_CTRL_ONE:
                            state_next.rdata = state_reg.tcr_one;
                        irq_unit_pkg::OFF_TIMER_CTRL_TWO:
                            state_next.rdata = state_reg.tcr_two;
                        irq_unit_pkg::OFF_IRQ_FLAGS:
                            state_next.rdata = state_reg.flags;
                        irq_unit_pkg::OFF_RESET_CAUSE:
                            state_next.rdata = {5'h00, state_reg.wake_flag,
                                                state_reg.timeout_flag,
                                                state_reg.powerdown_flag};
                        default:
                            state_next.rdata = '0;
                    endcase
                end
                irq_unit_pkg::SPACE_CTRL:
                begin
                    unique case (addr_i)
                        irq_unit_pkg::OFF_CMP_CTRL:
                            state_next.rdata = state_reg.cmp_ctrl;
                        irq_unit_pkg::OFF_CMP_SHARING:
                            state_next.rdata = {4'h0, state_reg.sharing};
                        irq_unit_pkg::OFF_IRQ_MASK:
                            state_next.rdata = state_reg.mask;
                        default:
                            state_next.rdata = '0;
                    endcase
                end
                irq_unit_pkg::SPACE_CNT:
                begin
                    unique case (addr_i)
                        irq_unit_pkg::OFF_AUX_A_COUNT:
                            state_next.rdata = state_reg.ta;
                        irq_unit_pkg::OFF_AUX_B_LOW:
                            state_next.rdata = state_reg.tb[7:0];
                        irq_unit_pkg::OFF_AUX_B_HIGH:
                            state_next.rdata = state_reg.tb[15:8];
                        irq_unit_pkg::OFF_AUX_C_COUNT:
                            state_next.rdata = state_reg.tc;
                        default:
                            state_next.rdata = '0;
                    endcase
                end
                default:
                    state_next.rdata = '0;
            endcase
        end

        // clock enable low freezes everything
        if (!clk_en_i)
            state_next = state_reg;
    end

    // power-on reset: cause bits 0,1,1 and core held for one cycle
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= '0;
            state_reg.timeout_flag <= 1'b1;
            state_reg.powerdown_flag <= 1'b1;
            state_reg.core_rst <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // no request while asleep; the core is stopped then
    assign irq_req_o = state_reg.gie && !state_reg.sleeping && |pending;
    assign rdata_o = state_reg.rdata;
    assign vector_o = state_reg.vector;
    assign saved_acc_o = state_reg.sacc;
    assign saved_status_o = state_reg.sstat;
    assign core_reset_o = state_reg.core_rst;
    assign sleep_o = state_reg.sleeping;
    assign wake_o = state_reg.wake_pulse;
    assign reset_cause_o = {state_reg.wake_flag, state_reg.timeout_flag,
                            state_reg.powerdown_flag};
    assign comparator_enable_o =
        state_reg.cmp_ctrl[irq_unit_pkg::CMP_EN_LOW +: irq_unit_pkg::NUM_CMP];
    assign input_sharing_select_o = state_reg.sharing;
    // pins only driven when software asked; direction setup is the user's job
    assign comparator_pin_o = state_reg.cmp_res;
    assign comparator_pin_oe_o =
        state_reg.cmp_ctrl[irq_unit_pkg::CMP_PIN_LOW +: irq_unit_pkg::NUM_CMP];
endmodule
`default_nettype wire

// ### design/irq_unit_pkg.sv
// constants for the vectored interrupt and event unit
// assumes one system clock; register spaces are chosen by a space select
package irq_unit_pkg;
    // register spaces
    localparam logic [1:0] SPACE_OPER = 2'h0;
    localparam logic [1:0] SPACE_CTRL = 2'h1;
    localparam logic [1:0] SPACE_CNT  = 2'h2;
    // operational space offsets
    localparam logic [5:0] OFF_TIMER_CMP_STATUS = 6'h09;
    localparam logic [5:0] OFF_TIMER_CTRL_ONE   = 6'h0A;
    localparam logic [5:0] OFF_TIMER_CTRL_TWO   = 6'h0B;
    localparam logic [5:0] OFF_IRQ_FLAGS        = 6'h0F;
    localparam logic [5:0] OFF_RESET_CAUSE      = 6'h10;
    // control space offsets
    localparam logic [5:0] OFF_CMP_CTRL         = 6'h09;
    localparam logic [5:0] OFF_CMP_SHARING      = 6'h0A;
    localparam logic [5:0] OFF_IRQ_MASK         = 6'h0F;
    // counter space offsets
    localparam logic [5:0] OFF_AUX_A_COUNT      = 6'h05;
    localparam logic [5:0] OFF_AUX_B_LOW        = 6'h06;
    localparam logic [5:0] OFF_AUX_B_HIGH       = 6'h07;
    localparam logic [5:0] OFF_AUX_C_COUNT      = 6'h08;
    // flag and mask layout
    localparam int BIT_MAIN_TIMER  = 0;
    localparam int BIT_PORT_CHANGE = 1;
    localparam int BIT_EXT_PIN     = 2;
    localparam int BIT_CMP_LOW     = 4;
    localparam logic [7:0] FLAG_USED_MASK = 8'hF7;
    // timer control layout, timer a and c in low nibble, b in high
    localparam int BIT_RUN_EN  = 0;
    localparam int BIT_SRC_SEL = 1;
    localparam int BIT_IRQ_EN  = 2;
    localparam int TB_NIBBLE   = 4;
    localparam logic [7:0] TCR_ONE_MASK = 8'h07;
    localparam logic [7:0] TCR_TWO_MASK = 8'h77;
    // comparator control layout: enables low, pin outputs high
    localparam int CMP_EN_LOW  = 0;
    localparam int CMP_PIN_LOW = 4;
    localparam int NUM_CMP     = 4;
    localparam int NUM_SRC     = 10;
    // vectors, lowest address first
    localparam logic [9:0] VECTOR_BASE = 10'h3EC;
    localparam logic [9:0] VECTOR_STEP = 10'h002;
    // aux timer top values
    localparam logic [15:0] TOP_8  = 16'h00FF;
    localparam logic [15:0] TOP_16 = 16'hFFFF;
endpackage

// ### verif/irq_unit_chk.sv
// port checker for the vectored interrupt unit
// assumes one clock domain, reset active high
`timescale 1ns/1ps
`default_nettype none
module irq_unit_chk (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       irq_take_i,
    input  wire logic       watchdog_timeout_i,
    input  wire logic       pin_reset_n_i,
    input  wire logic       sleep_instr_i,
    input  wire logic       watchdog_clear_instr_i,
    input  wire logic [7:0] acc_i,
    input  wire logic       irq_req_o,
    input  wire logic [9:0] vector_o,
    input  wire logic [7:0] saved_acc_o,
    input  wire logic       core_reset_o,
    input  wire logic [2:0] reset_cause_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_take_drops_req: assert property (irq_take_i && irq_req_o |=> !irq_req_o)
        else $error("request stays up after take");
    a_vector_on_take: assert property (irq_take_i && irq_req_o |=> vector_o >= 10'h3EC && !vector_o[0])
        else $error("vector outside table");
    // pin and watchdog resets leave the vector alone, yet the reset pulse is also accepted as explaining a change
    a_vector_cause: assert property ($changed(vector_o) |-> $past(irq_take_i && irq_req_o) || core_reset_o)
        else $error("vector changed without take");
    a_context_saved: assert property (irq_take_i && irq_req_o |=> saved_acc_o == $past(acc_i))
        else $error("accumulator not saved on take");
    a_wdt_resets: assert property (watchdog_timeout_i |=> core_reset_o)
        else $error("no reset on watchdog");
    a_pin_resets: assert property (!pin_reset_n_i |=> core_reset_o)
        else $error("no reset on pin low");
    a_wdt_cause: assert property (watchdog_timeout_i |=> reset_cause_o[2:1] == 2'b00)
        else $error("watchdog cause bits wrong");
    a_sleep_cause: assert property (sleep_instr_i |=> reset_cause_o[1:0] == 2'b10)
        else $error("sleep cause bits wrong");
    a_clear_cause: assert property (watchdog_clear_instr_i |=> reset_cause_o[1:0] == 2'b11)
        else $error("clear cause bits wrong");
endmodule
bind vectored_interrupt_and_event_unit irq_unit_chk chk_u (.*);
`default_nettype wire

// ### verif/core_model.sv
// core stand-in that takes a pending interrupt
// assumes the bench picks the fetch delay
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       irq_req_i,
    input  wire logic [3:0] delay_i,
    output logic            irq_take_o
);
    logic [3:0] wait_reg;
    // slow fetch: request must stand delay_i+1 cycles before the take
    always_ff @(posedge clock_i or posedge rst_i)
        if (rst_i)
        begin
            wait_reg   <= 4'h0;
            irq_take_o <= 1'b0;
        end
        else
        begin
            irq_take_o <= irq_req_i && !irq_take_o && wait_reg >= delay_i;
            wait_reg   <= (irq_req_i && !irq_take_o) ? wait_reg + 4'h1 : 4'h0;
        end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// bench for the vectored interrupt unit
// assumes reads answer one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clock_i = 1'b0, rst_i = 1'b1, pin_reset_n_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic        en = 1'b1;
    logic [1:0]  space_i = 2'h0;
    logic [5:0]  addr_i = 6'h00;
    logic [7:0]  wdata_i = 8'h00, port5_i = 8'h00, acc_i = 8'h00, rdata_o, sav, rv;
    logic        irq_take_i, irq_req_o, sleep_o, wake_o, core_reset_o;
    logic [9:0]  ev = 10'h000, vector_o;
    logic [3:0]  raw = 4'h0, delay = 4'h0;
    logic [2:0]  reset_cause_o, cause;
    logic [31:0] rnd = 32'h9FB9;
    int          n_fail = 0, cmp_count = 0, k;
    logic [7:0]  zero_tab [12] = '{8'h0A, 8'h0B, 8'h0F, 8'h09, 8'h49, 8'h4A, 8'h4F, 8'h85,
                                   8'h86, 8'h87, 8'h88, 8'h3F};
    vectored_interrupt_and_event_unit dut_u (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(en),
        .space_i(space_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pin_reset_n_i(pin_reset_n_i), .watchdog_timeout_i(ev[5]),
        .global_irq_on_instr_i(ev[0]), .global_irq_off_instr_i(ev[1]),
        .irq_return_instr_i(ev[2]), .sleep_instr_i(ev[3]), .watchdog_clear_instr_i(ev[4]),
        .main_timer_ovf_i(ev[6]), .ext_pin_event_i(ev[7]), .ir_event_i(ev[9]),
        .port5_i(port5_i), .port5_read_i(ev[8]), .comparator_raw_i(raw),
        .aux_ext_tick_i(1'b0), .irq_take_i(irq_take_i), .acc_i(acc_i), .status_i(rnd[15:8]),
        .irq_req_o(irq_req_o), .vector_o(vector_o), .saved_acc_o(sav), .saved_status_o(),
        .core_reset_o(core_reset_o), .sleep_o(sleep_o), .wake_o(wake_o),
        .reset_cause_o(reset_cause_o), .comparator_enable_o(), .input_sharing_select_o(),
        .comparator_pin_o(), .comparator_pin_oe_o());
    core_model core_u (.clock_i(clock_i), .rst_i(rst_i), .irq_req_i(irq_req_o),
        .delay_i(delay), .irq_take_o(irq_take_i));
    initial forever #25 clock_i = ~clock_i;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input string n, input logic [9:0] e, input logic [9:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // address byte: space in bits 7:6, offset below
    task automatic bus(input logic w, input logic [7:0] sa, input logic [7:0] d);
        space_i <= sa[7:6];
        addr_i  <= sa[5:0];
        wdata_i <= d;
        wr_i    <= w;
        rd_i    <= !w;
        @(posedge clock_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1 rv = rdata_o;
        @(posedge clock_i);
    endtask
    task automatic pulse(input int b);
        ev[b] <= 1'b1;
        @(posedge clock_i);
        ev <= 10'h000;
        @(posedge clock_i);
    endtask
    task automatic wait_for(input logic w);
        k = 0;
        do
        begin
            @(posedge clock_i);
            #1 k++;
        end
        while ((w ? wake_o : irq_take_i) !== 1'b1 && k < 40);
    endtask
    task automatic take_check(input logic [9:0] e);
        acc_i <= rnd[7:0];
        delay <= rnd[11:8];
        rnd = lfsr(rnd);
        wait_for(1'b0);
        @(posedge clock_i);
        #1 check("vector", e, vector_o);
        check("saved acc", {2'b00, acc_i}, {2'b00, sav});
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4000) @(posedge clock_i);
        n_fail++;
        finish_test;
    end
    initial
    begin
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        cause = 3'b011;
        check("cause", {7'h00, cause}, {7'h00, reset_cause_o});
        foreach (zero_tab[i])
        begin
            bus(1'b0, zero_tab[i], 8'h00);
            check("reset read", 10'h000, {2'b00, rv});
        end
        $display("reset test done");
        pulse(6);
        pulse(7);
        bus(1'b0, 8'h0F, 8'h00);
        check("flags", 10'h005, {2'b00, rv});
        check("masked request", 10'h000, {9'h000, irq_req_o});
        bus(1'b1, 8'h4F, 8'h05);
        pulse(0);
        take_check(10'h3FA);
        bus(1'b0, 8'h0F, 8'h00);
        check("flags held", 10'h005, {2'b00, rv});
        bus(1'b1, 8'h0F, 8'hFE);
        pulse(2);
        take_check(10'h3FC);
        bus(1'b1, 8'h0F, 8'h00);
        pulse(2);
        pulse(1);
        pulse(6);
        check("request with gie off", 10'h000, {9'h000, irq_req_o});
        en <= 1'b0;
        pulse(0);
        en <= 1'b1;
        check("frozen enable", 10'h000, {9'h000, irq_req_o});
        pulse(0);
        take_check(10'h3FA);
        bus(1'b1, 8'h49, 8'h0F);
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b1, 8'h0F, 8'h00);
            bus(1'b1, 8'h4F, 8'h10 << c);
            pulse(2);
            raw <= raw ^ (4'h1 << c);
            take_check(10'h3F2 - 10'(2 * c));
        end
        $display("vector test done");
        bus(1'b1, 8'h0F, 8'h00);
        bus(1'b1, 8'h4F, 8'h00);
        bus(1'b1, 8'h0A, 8'h05);
        bus(1'b1, 8'h85, 8'hFD);
        pulse(2);
        take_check(10'h3F8);
        bus(1'b1, 8'h0A, 8'h00);
        bus(1'b0, 8'h09, 8'h00);
        check("timer status", {2'b00, raw, 4'h1}, {2'b00, rv});
        bus(1'b1, 8'h09, 8'h00);
        $display("timer test done");
        pulse(3);
        cause = {cause[2], 2'b10};
        check("sleep cause", {7'h00, cause}, {7'h00, reset_cause_o});
        pin_reset_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        pin_reset_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        check("pin sleep cause", 10'h002, {7'h00, reset_cause_o});
        pulse(4);
        check("clear cause", 10'h003, {7'h00, reset_cause_o});
        pulse(3);
        pulse(5);
        @(posedge clock_i);
        check("wdt sleep cause", 10'h000, {7'h00, reset_cause_o});
        bus(1'b1, 8'h4F, 8'h02);
        pulse(8);
        pulse(3);
        port5_i <= rnd[7:0] | 8'h01;
        wait_for(1'b1);
        @(posedge clock_i);
        check("wake cause", 10'h006, {7'h00, reset_cause_o});
        check("in line", 10'h000, {9'h000, irq_req_o});
        pulse(0);
        take_check(10'h3FE);
        $display("cause test done");
        finish_test;
    end
endmodule
`default_nettype wire
